// ---- nvmc_defs.svh ----
`ifndef NVMC_DEFS_SVH
`define NVMC_DEFS_SVH
// Summary of operation
// - Controller sleeps with system when idle
// - Ongoing write keeps clock alive in sleep
// - Ready interrupt wakes from idle only
// - Wake-up clears page buffer
// - Command writes need unlock, else ignored
// - Command codes 1..7 decode to operations
// - Fuse write only from debug interface
// - Chip erase spares data memory if fuse
// - Boot lock blanks boot reads and fetches
// - Boot lock set from boot code, reset clears
// - Boot lock applies after leaving boot section
// - App protect is set-only, blocks app writes
// - Write fail flags failed last operation
// - Busy bits show data and program activity
// - Ready interrupt level, enable bit 0
// - Enabled ready interrupt requests while data memory idle
// - Ready flag cleared by writing one
// - Sixteen-bit fuse value at 0x06
// - Sixteen-bit address register at 0x08
// - Buffer clear sets ones, stalls seven cycles
// ============================================================
// Register offsets
`define NVMC_OFS_CMD 4'h0
`define NVMC_OFS_PROT 4'h1
`define NVMC_OFS_STAT 4'h2
`define NVMC_OFS_IEN 4'h3
`define NVMC_OFS_IFLG 4'h4
`define NVMC_OFS_DATL 4'h6
`define NVMC_OFS_DATH 4'h7
`define NVMC_OFS_ADRL 4'h8
`define NVMC_OFS_ADRH 4'h9
// ============================================================
// Field positions
`define NVMC_BIT_APP_WP 0
`define NVMC_BIT_BOOT_LOCK 1
`define NVMC_BIT_PM_BUSY 0
`define NVMC_BIT_DM_BUSY 1
`define NVMC_BIT_WFAIL 2
`define NVMC_BIT_READY 0
// ============================================================
// Timing
`define NVMC_CLEAR_CYCLES 3'h7
`define NVMC_CLEAR_LAST 3'h1
`define NVMC_BYTE_ZERO 8'h00
`define NVMC_WORD_ZERO 16'h0000
`endif

// ---- nvmc_pkg.sv ----
package nvmc_pkg;
    typedef enum logic [2:0] {
        NVMC_CMD_NONE, NVMC_CMD_WRITE, NVMC_CMD_ERASE, NVMC_CMD_ERASE_WRITE,
        NVMC_CMD_BUF_CLEAR, NVMC_CMD_CHIP_ERASE, NVMC_CMD_DM_ERASE, NVMC_CMD_FUSE
    } nvmc_cmd_e;
    typedef enum logic [1:0] {NVMC_IDLE, NVMC_RUN, NVMC_CLEAR} nvmc_state_e;
    typedef enum logic [1:0] {NVMC_SLEEP_NONE, NVMC_SLEEP_IDLE, NVMC_SLEEP_STANDBY,
        NVMC_SLEEP_POWER_DOWN} nvmc_sleep_e;
    // Order given to the arrays for one operation
    typedef struct packed {
        logic erase;
        logic write;
        logic chip;
        logic dm_all;
        logic fuse;
        logic keep_dm;
        logic to_dm;
        logic [15:0] addr;
        logic [15:0] data;
    } nvmc_op_s;
endpackage

// ---- nvmc_controller.sv ----
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`include "nvmc_defs.svh"
module nvmc_controller import nvmc_pkg::*; (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic key_unlocked,
    input wire logic from_debug,
    input wire logic exec_in_boot,
    input wire logic fetch_in_boot,
    input wire logic access_in_boot,
    input wire logic [1:0] sleep_mode,
    input wire logic wake_event,
    input wire logic preserve_data_memory_fuse,
    input wire logic target_is_dm,
    input wire logic target_is_app,
    input wire logic target_is_boot,
    input wire logic buffer_mixed,
    input wire logic array_done,
    output nvmc_op_s array_op,
    output logic array_start,
    output logic buffer_clear,
    output logic cpu_stall,
    output logic clock_request,
    output logic ctrl_asleep,
    output logic boot_block,
    output logic data_memory_ready_irq,
    output logic wake_request
);
    // ============================================================
    // Registers
    nvmc_cmd_e cmd;
    logic app_write_protect;
    logic boot_lock_req;
    logic boot_section_lock;
    logic write_fail;
    logic program_memory_busy;
    logic data_memory_busy;
    logic ready_enable;
    logic ready_flag;
    logic [15:0] fuse_value;
    logic [15:0] last_loc;
    nvmc_state_e state;
    logic [2:0] clear_cnt;
    logic was_asleep;
    logic cmd_wr;
    logic accept;
    logic prot_fail;
    logic dm_target;
    logic dm_touch;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        return reg_wr && (a == ofs);
    endfunction

    // Unlocked write while idle only; a locked attempt is ignored
    assign cmd_wr = hit(reg_addr, `NVMC_OFS_CMD) && key_unlocked;
    assign accept = cmd_wr && (state == NVMC_IDLE) && (cmd == NVMC_CMD_NONE)
        && (reg_wdata[2:0] != 3'h0)
        && !((nvmc_cmd_e'(reg_wdata[2:0]) == NVMC_CMD_FUSE) && !from_debug);
    assign dm_target = target_is_dm;
    // Whole-array commands that reach the data memory
    assign dm_touch = (nvmc_cmd_e'(reg_wdata[2:0]) == NVMC_CMD_DM_ERASE)
        || ((nvmc_cmd_e'(reg_wdata[2:0]) == NVMC_CMD_CHIP_ERASE)
        && !preserve_data_memory_fuse);
    // Chip erase ignores section protection
    assign prot_fail = ((target_is_app && app_write_protect)
        || (target_is_boot && boot_section_lock)) && !dm_target;

    // ============================================================
    // Command sequencer
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cmd <= NVMC_CMD_NONE;
            state <= NVMC_IDLE;
            clear_cnt <= 3'h0;
            write_fail <= 1'b0;
            program_memory_busy <= 1'b0;
            data_memory_busy <= 1'b0;
            array_start <= 1'b0;
            array_op <= '0;
        end else begin
            array_start <= 1'b0;
            unique case (state)
                NVMC_IDLE: begin
                    if (accept) begin
                        cmd <= nvmc_cmd_e'(reg_wdata[2:0]);
                        array_op <= '0;
                        array_op.addr <= last_loc;
                        array_op.data <= fuse_value;
                        array_op.to_dm <= dm_target;
                        unique case (nvmc_cmd_e'(reg_wdata[2:0]))
                            NVMC_CMD_BUF_CLEAR: begin
                                state <= NVMC_CLEAR;
                                clear_cnt <= `NVMC_CLEAR_CYCLES;
                            end
                            NVMC_CMD_WRITE, NVMC_CMD_ERASE, NVMC_CMD_ERASE_WRITE: begin
                                if (prot_fail || buffer_mixed) begin
                                    write_fail <= 1'b1;
                                    cmd <= NVMC_CMD_NONE;
                                end else begin
                                    write_fail <= 1'b0;
                                    state <= NVMC_RUN;
                                    array_start <= 1'b1;
                                    array_op.erase <= reg_wdata[1];
                                    array_op.write <= reg_wdata[0];
                                    data_memory_busy <= dm_target;
                                    program_memory_busy <= !dm_target;
                                end
                            end
                            default: begin
                                write_fail <= 1'b0;
                                state <= NVMC_RUN;
                                array_start <= 1'b1;
                                array_op.chip <= (reg_wdata[2:0] == NVMC_CMD_CHIP_ERASE);
                                array_op.keep_dm <= preserve_data_memory_fuse;
                                array_op.dm_all <= (reg_wdata[2:0] == NVMC_CMD_DM_ERASE);
                                array_op.fuse <= (reg_wdata[2:0] == NVMC_CMD_FUSE);
                                program_memory_busy <= (reg_wdata[2:0] != NVMC_CMD_DM_ERASE);
                                data_memory_busy <= dm_touch;
                                array_op.to_dm <= dm_touch;
                            end
                        endcase
                    end
                end
                NVMC_RUN: begin
                    if (array_done) begin
                        state <= NVMC_IDLE;
                        cmd <= NVMC_CMD_NONE;
                        program_memory_busy <= 1'b0;
                        data_memory_busy <= 1'b0;
                    end
                end
                NVMC_CLEAR: begin
                    if (clear_cnt == `NVMC_CLEAR_LAST) begin
                        state <= NVMC_IDLE;
                        cmd <= NVMC_CMD_NONE;
                    end
                    clear_cnt <= clear_cnt - 3'h1;
                end
                default: state <= NVMC_IDLE;
            endcase
        end
    end

    // ============================================================
    // Protection bits
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            app_write_protect <= 1'b0;
            boot_lock_req <= 1'b0;
            boot_section_lock <= 1'b0;
        end else begin
            if (hit(reg_addr, `NVMC_OFS_PROT)) begin
                if (reg_wdata[`NVMC_BIT_APP_WP])
                    app_write_protect <= 1'b1;
                if (reg_wdata[`NVMC_BIT_BOOT_LOCK] && exec_in_boot)
                    boot_lock_req <= 1'b1;
            end
            if (boot_lock_req && !exec_in_boot)
                boot_section_lock <= 1'b1;
        end
    end
    assign boot_block = boot_section_lock && (fetch_in_boot || access_in_boot);

    // ============================================================
    // Ready interrupt, fuse value and address
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ready_enable <= 1'b0;
            ready_flag <= 1'b0;
            fuse_value <= `NVMC_WORD_ZERO;
            last_loc <= `NVMC_WORD_ZERO;
        end else begin
            if (hit(reg_addr, `NVMC_OFS_IEN))
                ready_enable <= reg_wdata[`NVMC_BIT_READY];
            // Set wins over a simultaneous clear
            if (!data_memory_busy)
                ready_flag <= 1'b1;
            else if (hit(reg_addr, `NVMC_OFS_IFLG) && reg_wdata[`NVMC_BIT_READY])
                ready_flag <= 1'b0;
            if (hit(reg_addr, `NVMC_OFS_DATL))
                fuse_value[7:0] <= reg_wdata;
            if (hit(reg_addr, `NVMC_OFS_DATH))
                fuse_value[15:8] <= reg_wdata;
            if (hit(reg_addr, `NVMC_OFS_ADRL))
                last_loc[7:0] <= reg_wdata;
            if (hit(reg_addr, `NVMC_OFS_ADRH))
                last_loc[15:8] <= reg_wdata;
        end
    end
    // Level request while enabled and the data memory is idle
    assign data_memory_ready_irq = ready_enable && !data_memory_busy;
    assign wake_request = data_memory_ready_irq
        && (nvmc_sleep_e'(sleep_mode) == NVMC_SLEEP_IDLE);

    // ============================================================
    // Sleep handling
    assign clock_request = (state != NVMC_IDLE);
    assign ctrl_asleep = (nvmc_sleep_e'(sleep_mode) != NVMC_SLEEP_NONE)
        && (state == NVMC_IDLE);
    assign cpu_stall = (state == NVMC_CLEAR) || program_memory_busy;
    always_ff @(posedge clock) begin
        if (!rst_b)
            was_asleep <= 1'b0;
        else
            was_asleep <= (nvmc_sleep_e'(sleep_mode) != NVMC_SLEEP_NONE) && !wake_event;
    end
    assign buffer_clear = (state == NVMC_CLEAR) && (clear_cnt == `NVMC_CLEAR_LAST)
        || (was_asleep && ((nvmc_sleep_e'(sleep_mode) == NVMC_SLEEP_NONE)
        || wake_event));

    // ============================================================
    // Read port, reserved bits read zero
    always_ff @(posedge clock) begin
        if (!rst_b)
            reg_rdata <= `NVMC_BYTE_ZERO;
        else if (reg_rd) begin
            unique case (reg_addr)
                `NVMC_OFS_CMD: reg_rdata <= {5'h00, cmd};
                `NVMC_OFS_PROT: reg_rdata <= {6'h00, boot_lock_req, app_write_protect};
                `NVMC_OFS_STAT: reg_rdata <= {5'h00, write_fail, data_memory_busy,
                    program_memory_busy};
                `NVMC_OFS_IEN: reg_rdata <= {7'h00, ready_enable};
                `NVMC_OFS_IFLG: reg_rdata <= {7'h00, ready_flag};
                `NVMC_OFS_DATL: reg_rdata <= fuse_value[7:0];
                `NVMC_OFS_DATH: reg_rdata <= fuse_value[15:8];
                `NVMC_OFS_ADRL: reg_rdata <= last_loc[7:0];
                `NVMC_OFS_ADRH: reg_rdata <= last_loc[15:8];
                default: reg_rdata <= `NVMC_BYTE_ZERO;
            endcase
        end else
            reg_rdata <= `NVMC_BYTE_ZERO;
    end
endmodule // nvmc_controller

// ---- nvmc_array_model.sv ----
`timescale 1ns/1ps
// ==========
// Array model: answers each start after a fixed delay
module nvmc_array_model #(parameter int DLY = 12) (
    input wire logic clock,
    input wire logic array_start,
    output logic array_done
);
    int cnt = 0;
    initial array_done = 1'b0;
    // Done comes DLY cycles late, so busy spans several bus reads
    always @(posedge clock) begin
        array_done <= (cnt == 1);
        if (array_start) cnt <= DLY;
        else if (cnt != 0) cnt <= cnt - 1;
    end
endmodule // nvmc_array_model

// ---- nvmc_monitor.sv ----
`timescale 1ns/1ps
// ==========
// Checker
module nvmc_monitor import nvmc_pkg::*; (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic key_unlocked,
    input wire logic from_debug,
    input wire logic [1:0] sleep_mode,
    input wire logic wake_event,
    input wire logic preserve_data_memory_fuse,
    input wire logic array_done,
    input nvmc_op_s array_op,
    input wire logic array_start,
    input wire logic buffer_clear,
    input wire logic cpu_stall,
    input wire logic clock_request,
    input wire logic ctrl_asleep,
    input wire logic data_memory_ready_irq,
    input wire logic wake_request
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence clear_run;
        cpu_stall [*6] ##1 (cpu_stall && buffer_clear);
    endsequence
    a_stall_seven: assert property (reg_wr && key_unlocked && reg_addr == 4'h0
        && reg_wdata[2:0] == 3'h4 && !clock_request |=> clear_run ##1 !cpu_stall)
        else $error("buffer clear stall wrong");
    a_start_pulse: assert property (array_start |=> !array_start)
        else $error("start repeated");
    a_fuse_source: assert property (array_start && array_op.fuse |-> $past(from_debug))
        else $error("fuse write from cpu");
    a_chip_keep: assert property (array_start && array_op.chip |->
        array_op.keep_dm == preserve_data_memory_fuse) else $error("chip erase keep wrong");
    a_write_awake: assert property (array_start |->
        (clock_request && !ctrl_asleep) throughout ##[1:63] array_done)
        else $error("slept during write");
    a_idle_sleeps: assert property (sleep_mode != 2'h0 && !clock_request && !wake_event
        |-> ctrl_asleep) else $error("idle controller awake");
    a_ready_wake: assert property (sleep_mode == 2'h1 && data_memory_ready_irq
        |-> wake_request) else $error("no wake from idle");
    a_deep_no_wake: assert property (sleep_mode[1] && !wake_event |-> !wake_request)
        else $error("wake from deep sleep");
    a_dm_irq_off: assert property (array_start && array_op.to_dm
        |-> !data_memory_ready_irq) else $error("ready while busy");
    a_wake_clear: assert property (wake_event && sleep_mode != 2'h0
        |-> ##[0:2] buffer_clear) else $error("no clear on wake");
endmodule // nvmc_monitor
bind nvmc_controller nvmc_monitor u_mon (.clock, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
    .key_unlocked, .from_debug, .sleep_mode, .wake_event, .preserve_data_memory_fuse,
    .array_done, .array_op, .array_start, .buffer_clear, .cpu_stall, .clock_request,
    .ctrl_asleep, .data_memory_ready_irq, .wake_request);

// ---- nvmc_controller_tb_top.sv ----
`timescale 1ns/1ps
module nvmc_controller_tb_top import nvmc_pkg::*; ;
    logic clock, rst_b, reg_wr, reg_rd, key_unlocked, from_debug, exec_in_boot;
    logic fetch_in_boot, access_in_boot, wake_event, preserve_data_memory_fuse;
    logic target_is_dm, target_is_app, target_is_boot, buffer_mixed, array_done;
    logic array_start, buffer_clear, cpu_stall, clock_request, ctrl_asleep;
    logic boot_block, data_memory_ready_irq, wake_request;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d;
    logic [1:0] sleep_mode;
    nvmc_op_s array_op, op;
    logic [3:0] dec [1:6] = '{4'h4, 4'h8, 4'hc, 4'h0, 4'h2, 4'h1};
    int miscompares = 0, checks = 0, starts = 0, exp_s = 0;
    nvmc_controller dut (.*);
    nvmc_array_model #(.DLY(12)) u_arr (.clock, .array_start, .array_done);
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    always @(posedge clock) if (array_start) begin
        starts <= starts + 1;
        op <= array_op;
    end
    // ==========
    // Bus tasks
    task chk(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task rdc(input logic [3:0] a, input logic [7:0] e);
        rd(a, d);
        chk(d, e);
    endtask
    task cmd(input logic [2:0] c);
        key_unlocked <= 1'b1;
        wr(4'h0, {5'h00, c});
        key_unlocked <= 1'b0;
    endtask
    // Software polls both busy bits before the next command
    task wait_idle;
        int i;
        d = 8'h03;
        for (i = 0; i < 40 && d[1:0] !== 2'h0; i++) rd(4'h2, d);
        chk(d[1:0], 2'h0);
        repeat (8) @(posedge clock);
    endtask
    task wrap_up;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #100000;
        miscompares++;
        wrap_up();
    end
    // ==========
    // Tests
    initial begin
        {rst_b, reg_wr, reg_rd, key_unlocked, from_debug, exec_in_boot} = 6'h00;
        {fetch_in_boot, access_in_boot, wake_event, target_is_app, target_is_boot} = 5'h00;
        {buffer_mixed, reg_addr, reg_wdata, sleep_mode} = 15'h0000;
        {preserve_data_memory_fuse, target_is_dm} = 2'h3;
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        for (int a = 0; a < 10; a++) rdc(a[3:0], (a == 4) ? 8'h01 : 8'h00);
        wr(4'h0, 8'h01);
        rdc(4'h0, 8'h00);
        for (int a = 5; a < 10; a++) wr(a[3:0], 8'h30 + a[7:0]);
        for (int a = 5; a < 10; a++) rdc(a[3:0], (a == 5) ? 8'h00 : 8'h30 + a[7:0]);
        wr(4'h3, 8'h01);
        #1 chk(data_memory_ready_irq, 1'b1);
        for (int c = 1; c < 7; c++) begin
            cmd(c[2:0]);
            if (c != 4) exp_s++;
            if (c == 1) rdc(4'h2, 8'h02);
            if (c == 1) chk(data_memory_ready_irq, 1'b0);
            if (c == 2) wr(4'h4, 8'h01);
            if (c == 2) rdc(4'h4, 8'h00);
            if (c == 3) begin
                sleep_mode <= 2'h3;
                repeat (20) @(posedge clock);
                #1 chk(ctrl_asleep, 1'b1);
                wake_event <= 1'b1;
                @(posedge clock);
                wake_event <= 1'b0;
                sleep_mode <= 2'h1;
                repeat (2) @(posedge clock);
                #1 chk(wake_request, 1'b1);
                sleep_mode <= 2'h0;
            end
            wait_idle();
            chk(starts[15:0], exp_s[15:0]);
            if (c != 4) chk({op.erase & (c < 4), op.write, op.chip, op.dm_all}, dec[c]);
            if (c == 5) chk(op.keep_dm, 1'b1);
            rdc(4'h0, 8'h00);
        end
        chk(data_memory_ready_irq, 1'b1);
        cmd(3'h7);
        repeat (4) @(posedge clock);
        chk(starts[15:0], exp_s[15:0]);
        from_debug <= 1'b1;
        cmd(3'h7);
        wait_idle();
        chk(op.data, 16'h3736);
        chk(op.addr, 16'h3938);
        from_debug <= 1'b0;
        {target_is_dm, target_is_app} <= 2'h1;
        cmd(3'h1);
        rdc(4'h2, 8'h01);
        wait_idle();
        wr(4'h1, 8'h03);
        wr(4'h1, 8'h00);
        rdc(4'h1, 8'h01);
        cmd(3'h1);
        rdc(4'h2, 8'h04);
        exec_in_boot <= 1'b1;
        access_in_boot <= 1'b1;
        wr(4'h1, 8'h02);
        rdc(4'h1, 8'h03);
        chk(boot_block, 1'b0);
        exec_in_boot <= 1'b0;
        repeat (2) @(posedge clock);
        #1 chk(boot_block, 1'b1);
        wr(4'h3, 8'h00);
        #1 chk(data_memory_ready_irq, 1'b0);
        wrap_up();
    end
endmodule // nvmc_controller_tb_top
